// ==== hw/sqgr_pkg.sv ====
// Package: offsets, fields, reset values and states of the serial module global register bank
package sqgr_pkg;

	// Register byte offsets
	localparam logic [11:0] ModuleConfigOff   = 12'h800;
	localparam logic [11:0] ModuleTestOff     = 12'h802;
	localparam logic [11:0] IrqLevelOff       = 12'h804;
	localparam logic [11:0] IrqVectorOff      = 12'h805;
	localparam logic [11:0] PortDataOff       = 12'h815;
	localparam logic [11:0] PinAssignOff      = 12'h816;
	localparam logic [11:0] PortDirOff        = 12'h817;
	localparam logic [11:0] QueueStatusOff    = 12'h81e;

	// Module configuration fields
	localparam int StopBit         = 15;
	localparam int FreezeSelBit    = 14;
	localparam int SupvBit         = 7;
	localparam int ArbIdLsb        = 0;
	localparam logic [15:0] ModuleConfigRst = 16'h0080;
	localparam logic [15:0] ModuleConfigWMask = 16'hc08f;

	// Module test fields
	localparam int ScanSelBit      = 3;
	localparam int ScanEnBit       = 1;
	localparam logic [15:0] ModuleTestWMask = 16'h000a;

	// Level and vector fields
	localparam int LevelLsb        = 3;
	localparam logic [7:0] IrqLevelRst  = 8'h00;
	localparam logic [7:0] IrqVectorRst = 8'h0f;

	// Queue status / control fields (control bits in high byte, flags in low byte of status register)
	localparam int HaltReqBit      = 8;
	localparam int HaltFaultIeBit  = 9;
	localparam int DoneIeBit       = 10;
	localparam int SerialEnBit     = 11;
	localparam int DoneFlagBit     = 7;
	localparam int FaultFlagBit    = 6;
	localparam int HaltAckFlagBit  = 5;

	// Queue engine state
	typedef enum logic [1:0] {
		SqgrIdle = 2'b00,
		SqgrRun  = 2'b01,
		SqgrHalt = 2'b10
	} sqgr_eng_type;

endpackage

// ==== hw/sqgr_read_reg.sv ====
// Registered read-data return stage for the register bank
module sqgr_read_reg (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        clkEn,
	// Read data
	input  wire logic [15:0] rdIn,
	input  wire logic        loadEn,
	output logic      [15:0] rdOut
);

	typedef struct packed {
		logic [15:0] data;
	} sqgr_rd_type;

	sqgr_rd_type st_q;
	sqgr_rd_type st_d;

	always_comb begin
		st_d = st_q;
		if (loadEn) begin
			st_d.data = rdIn;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else if (clkEn) begin
			st_q <= st_d;
		end
	end

	assign rdOut = st_q.data;

endmodule // sqgr_read_reg

// ==== hw/sqgr_regs.sv ====
// Global configuration, test and interrupt register bank of the serial module
//////////////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Idle after reset until enable bit set
// - Config register writable in supervisor mode only
// - Stop bit gates module clock
// - Stopped: only config readable, writes still work
// - Stop cleared by write or reset
// - Freeze select halts on transfer boundary
// - Freeze holds pins, resumes automatically
// - Supervisor-only select: user access unacknowledged
// - Otherwise acknowledged; restricted register unimplemented
// - Arbitration ID zero skips acknowledge arbitration
// - Test register only in test mode
// - Level register supervisor only
// - Level field sets priority, zero disables
// - Vector resets to 0x0f until written
// - Acknowledge drives vector 7:1, bit0 high
// - Vector bit0 write ignored, reads one
// - Done and halt/fault flags raise requests
module sqgr_regs (
	// Clock, reset, enable
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        clkEn,
	// Intermodule bus slave
	input  wire logic        busValid,
	input  wire logic        busWrite,
	input  wire logic        busSuper,
	input  wire logic [11:0] busAddr,
	input  wire logic [15:0] busWdata,
	input  wire logic [1:0]  busByteEn,
	output logic             addressAck,
	output logic             busErr,
	output logic      [15:0] busRdata,
	// Acknowledge cycle and system signals
	input  wire logic        ackCycle,
	input  wire logic [2:0]  ackLevel,
	input  wire logic        freezeIn,
	input  wire logic        testMode,
	// Serial engine events
	input  wire logic        xferBoundary,
	input  wire logic        queueDone,
	input  wire logic        modeFault,
	// Block outputs
	output logic             moduleClkEn,
	output logic             engineRun,
	output logic             pinHold,
	output logic      [2:0]  irqLevel,
	output logic             arbRequest,
	output logic      [3:0]  arbId,
	output logic      [7:0]  ackVector,
	output logic             scanEnable,
	output logic             scanSelect
);

	typedef struct packed {
		logic [15:0]              cfg;
		logic [15:0]              tst;
		logic [7:0]               lvl;
		logic [7:0]               vec;
		logic [7:0]               pdat;
		logic [7:0]               pasg;
		logic [7:0]               pdir;
		logic [3:0]               ctl;
		logic                     doneF;
		logic                     faultF;
		logic                     haltAckF;
		sqgr_pkg::sqgr_eng_type   eng;
		logic [1:0]               frz;
		logic                     ack;
		logic                     err;
		logic                     rdLoad;
		logic                     modClk;
		logic                     run;
		logic                     hold;
		logic                     irq;
		logic [7:0]               vecOut;
	} sqgr_state_type;

	sqgr_state_type st_q;
	sqgr_state_type st_d;
	logic [15:0]    rdNext;
	logic [15:0]    rdData;

	//////////////////////////////////////////////////////////////////////////////////////////
	// Byte-lane merge, used for the config and test registers
	function automatic logic [15:0] mergeWr(input logic [15:0] old, input logic [15:0] wd,
		input logic [1:0] be, input logic [15:0] msk);
		logic [15:0] lane;
		lane = {{8{be[1]}}, {8{be[0]}}} & msk;
		return (old & ~lane) | (wd & lane);
	endfunction

	//////////////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic supvOnly;
		logic stopped;
		logic userDeny;
		logic hit;
		logic wr;
		logic rd;
		logic frzHalt;
		logic haltWant;
		logic [15:0] w;
		supvOnly = st_q.cfg[sqgr_pkg::SupvBit];
		stopped  = st_q.cfg[sqgr_pkg::StopBit];
		frzHalt  = st_q.frz[1] & st_q.cfg[sqgr_pkg::FreezeSelBit];
		haltWant = st_q.ctl[sqgr_pkg::HaltReqBit - 8] | frzHalt;
		wr = 1'b0;
		rd = 1'b0;
		st_d = st_q;
		// Freeze pin is asynchronous: only the second stage is read
		st_d.frz = {st_q.frz[0], freezeIn};
		rdNext = 16'h0000;
		hit = 1'b1;
		userDeny = 1'b0;
		st_d.ack = 1'b0;
		st_d.err = 1'b0;
		st_d.rdLoad = 1'b0;
		w = busWdata;
		// Word-aligned reads see the odd byte in the low lane
		unique case (busAddr)
			sqgr_pkg::ModuleConfigOff: begin
				rdNext = st_q.cfg;
				userDeny = !busSuper;
			end
			sqgr_pkg::ModuleTestOff: begin
				rdNext = st_q.tst;
				hit = testMode;
			end
			sqgr_pkg::IrqLevelOff: begin
				rdNext = {st_q.lvl, st_q.vec | 8'h01};
				userDeny = !busSuper;
			end
			sqgr_pkg::IrqVectorOff: begin
				rdNext = {8'h00, st_q.vec | 8'h01};
				userDeny = !busSuper;
			end
			sqgr_pkg::PortDataOff: rdNext = {8'h00, st_q.pdat};
			sqgr_pkg::PinAssignOff: rdNext = {st_q.pasg, st_q.pdir};
			sqgr_pkg::PortDirOff: rdNext = {8'h00, st_q.pdir};
			sqgr_pkg::QueueStatusOff: begin
				rdNext = {4'h0, st_q.ctl, st_q.doneF, st_q.faultF, st_q.haltAckF, 5'h00};
			end
			default: hit = 1'b0;
		endcase
		// Stop: only config stays readable
		if (stopped && busAddr != sqgr_pkg::ModuleConfigOff) begin
			rdNext = 16'h0000;
		end
		if (busValid) begin
			if (supvOnly && !busSuper) begin
				st_d.ack = 1'b0;
			end else if (!hit || userDeny) begin
				st_d.ack = 1'b1;
				st_d.err = 1'b1;
			end else begin
				st_d.ack = 1'b1;
				wr = busWrite;
				rd = !busWrite;
			end
		end
		st_d.rdLoad = rd;
		// Writes land even while stopped
		if (wr) begin
			unique case (busAddr)
				sqgr_pkg::ModuleConfigOff: st_d.cfg = mergeWr(st_q.cfg, w, busByteEn,
					sqgr_pkg::ModuleConfigWMask);
				sqgr_pkg::ModuleTestOff: st_d.tst = mergeWr(st_q.tst, w, busByteEn,
					sqgr_pkg::ModuleTestWMask);
				sqgr_pkg::IrqLevelOff: begin
					if (busByteEn[1]) begin
						st_d.lvl = {2'h0, w[13:11], 3'h0};
					end
					if (busByteEn[0]) begin
						st_d.vec = {w[7:1], 1'b1};
					end
				end
				sqgr_pkg::IrqVectorOff: st_d.vec = {w[7:1], 1'b1};
				sqgr_pkg::PortDataOff: st_d.pdat = {3'h0, w[4:0]};
				sqgr_pkg::PinAssignOff: st_d.pasg = {3'h0, w[12:11], 1'b0, w[9:8]};
				sqgr_pkg::PortDirOff: st_d.pdir = {3'h0, w[4:0]};
				sqgr_pkg::QueueStatusOff: st_d.ctl = w[11:8];
				default: st_d.cfg = st_q.cfg;
			endcase
		end
		// Engine: idle until enabled, halts on boundary
		unique case (st_q.eng)
			sqgr_pkg::SqgrIdle: begin
				if (st_q.ctl[sqgr_pkg::SerialEnBit - 8]) begin
					st_d.eng = sqgr_pkg::SqgrRun;
				end
			end
			sqgr_pkg::SqgrRun: begin
				if (!st_q.ctl[sqgr_pkg::SerialEnBit - 8]) begin
					st_d.eng = sqgr_pkg::SqgrIdle;
				end else if (haltWant && xferBoundary) begin
					st_d.eng = sqgr_pkg::SqgrHalt;
				end
			end
			sqgr_pkg::SqgrHalt: begin
				// Disabling while halted must not resume the queue
				if (!st_q.ctl[sqgr_pkg::SerialEnBit - 8]) begin
					st_d.eng = sqgr_pkg::SqgrIdle;
				end else if (!haltWant) begin
					st_d.eng = sqgr_pkg::SqgrRun;
				end
			end
			default: st_d.eng = sqgr_pkg::SqgrIdle;
		endcase
		// Flags: set wins over a clearing write of zero
		if (wr && busAddr == sqgr_pkg::QueueStatusOff && busByteEn[0]) begin
			st_d.doneF = st_q.doneF & w[sqgr_pkg::DoneFlagBit];
			st_d.faultF = st_q.faultF & w[sqgr_pkg::FaultFlagBit];
		end
		if (queueDone && st_q.eng == sqgr_pkg::SqgrRun) begin
			st_d.doneF = 1'b1;
		end
		if (modeFault) begin
			st_d.faultF = 1'b1;
		end
		st_d.haltAckF = (st_d.eng == sqgr_pkg::SqgrHalt);
		st_d.modClk = !st_d.cfg[sqgr_pkg::StopBit];
		st_d.run = (st_d.eng == sqgr_pkg::SqgrRun);
		st_d.hold = (st_d.eng == sqgr_pkg::SqgrHalt);
		st_d.irq = (st_d.lvl[5:3] != 3'h0) && (st_d.cfg[3:0] != 4'h0) &&
			((st_d.doneF && st_d.ctl[sqgr_pkg::DoneIeBit - 8]) ||
			((st_d.haltAckF || st_d.faultF) && st_d.ctl[sqgr_pkg::HaltFaultIeBit - 8]));
		st_d.vecOut = 8'h00;
		if (ackCycle && ackLevel == st_q.lvl[5:3] && st_q.cfg[3:0] != 4'h0 && st_q.irq) begin
			st_d.vecOut = {st_q.vec[7:1], 1'b1};
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.cfg <= sqgr_pkg::ModuleConfigRst;
			st_q.lvl <= sqgr_pkg::IrqLevelRst;
			st_q.vec <= sqgr_pkg::IrqVectorRst;
			st_q.modClk <= 1'b1;
			st_q.eng <= sqgr_pkg::SqgrIdle;
		end else if (clkEn) begin
			st_q <= st_d;
		end
	end

	sqgr_read_reg readStage (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clkEn    (clkEn),
		.rdIn     (rdNext),
		.loadEn   (st_d.rdLoad),
		.rdOut    (rdData)
	);

	assign addressAck  = st_q.ack;
	assign busErr      = st_q.err;
	assign busRdata    = rdData;
	assign moduleClkEn = st_q.modClk;
	assign engineRun   = st_q.run;
	assign pinHold     = st_q.hold;
	assign irqLevel    = st_q.lvl[5:3];
	assign arbRequest  = st_q.irq;
	assign arbId       = st_q.cfg[3:0];
	assign ackVector   = st_q.vecOut;
	assign scanEnable  = st_q.tst[sqgr_pkg::ScanEnBit];
	assign scanSelect  = st_q.tst[sqgr_pkg::ScanSelBit];

	//////////////////////////////////////////////////////////////////////////////////////////
	stop_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		moduleClkEn == !st_q.cfg[sqgr_pkg::StopBit])
		else $error("module clock enable disagrees with stop bit");
	lvl_protect_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clkEn && busValid && !busSuper && busAddr == sqgr_pkg::IrqLevelOff)
		|=> $stable(st_q.lvl))
		else $error("user write changed interrupt level");
	user_noack_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clkEn && busValid && !busSuper && st_q.cfg[7]) |=> !addressAck)
		else $error("user access acknowledged while supervisor only");
	user_ack_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clkEn && busValid && !busSuper && !st_q.cfg[7]) |=> addressAck)
		else $error("user access not acknowledged");
	cfg_protect_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clkEn && busValid && !busSuper && busAddr == 12'h800) |=> $stable(st_q.cfg))
		else $error("user write changed config");
	vec_bit0_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_q.vec[0]) else $error("vector bit zero not one");
	ack_vector_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ackVector != 8'h00 |-> ackVector[0] && ackVector[7:1] == $past(st_q.vec[7:1]))
		else $error("acknowledge vector wrong");
	arb_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		arbId == 4'h0 |-> !arbRequest) else $error("arbitrating with id zero");
	freeze_halt_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clkEn && !st_q.cfg[14] && !st_q.ctl[0] && st_q.eng == sqgr_pkg::SqgrRun
		&& st_q.ctl[3]) |=> st_q.eng != sqgr_pkg::SqgrHalt)
		else $error("halted without request");
	level_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		irqLevel == 3'h0 |-> !st_q.irq) else $error("request at level zero");
	test_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(clkEn && !testMode && busAddr == 12'h802) |=> $stable(st_q.tst))
		else $error("test register written outside test mode");
	idle_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!st_q.ctl[3] && clkEn |=> !engineRun) else $error("engine ran while disabled");

endmodule // sqgr_regs

// ==== verif/sqgr_bus_model.sv ====
// Processor-side bus master model for the register bank slave port
module sqgr_bus_model (
	// Clock
	core_clk,
	// Request
	busValid,
	busWrite,
	busSuper,
	busAddr,
	busWdata,
	busByteEn,
	// Answer
	addressAck,
	busErr,
	busRdata
);
	timeunit 1ns;
	timeprecision 1ps;
	input  wire logic        core_clk;
	output logic             busValid  = 1'b0;
	output logic             busWrite  = 1'b0;
	output logic             busSuper  = 1'b0;
	output logic      [11:0] busAddr   = 12'h000;
	output logic      [15:0] busWdata  = 16'h0000;
	output logic      [1:0]  busByteEn = 2'h0;
	input  wire logic        addressAck;
	input  wire logic        busErr;
	input  wire logic [15:0] busRdata;

	// One access; valid stands one cycle only, since every sampled edge is a new access
	task automatic xfer(input logic wr, input logic sup, input logic [11:0] a,
		input logic [15:0] wd, input logic [1:0] be,
		output logic ack, output logic err, output logic [15:0] rd);
		@(posedge core_clk);
		busValid  <= 1'b1;
		busWrite  <= wr;
		busSuper  <= sup;
		busAddr   <= a;
		busWdata  <= wd;
		busByteEn <= be;
		@(posedge core_clk);
		busValid  <= 1'b0;
		// Released address and data lines flip so stale values are never mistaken for live ones
		busAddr   <= ~a;
		busWdata  <= ~wd;
		@(negedge core_clk);
		ack = addressAck;
		err = busErr;
		rd  = busRdata;
	endtask
endmodule // sqgr_bus_model

// ==== verif/sqgr_regs_tb_top.sv ====
// Self-checking testbench of the serial module global register bank
module sqgr_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 1'b0;
	logic        rst_n    = 1'b0;
	logic        freezeIn = 1'b0;
	logic        testMode = 1'b0;
	logic        clkEn    = 1'b1;
	logic        ackCycle = 1'b0;
	logic [2:0]  ackLevel = 3'h0;
	logic [2:0]  evt      = 3'h0;
	logic        busValid, busWrite, busSuper, addressAck, busErr, ack, err;
	logic [11:0] busAddr;
	logic [15:0] busWdata, busRdata, rd;
	logic [1:0]  busByteEn;
	logic        moduleClkEn, engineRun, pinHold, arbRequest, scanEnable, scanSelect;
	logic [2:0]  irqLevel, lvl;
	logic [3:0]  arbId, id;
	logic [7:0]  ackVector, vec;
	int          nErrors  = 0;
	int          compares = 0;

	always #12.5 core_clk = ~core_clk;

	sqgr_bus_model cpu (.core_clk(core_clk), .busValid(busValid), .busWrite(busWrite),
		.busSuper(busSuper), .busAddr(busAddr), .busWdata(busWdata), .busByteEn(busByteEn),
		.addressAck(addressAck), .busErr(busErr), .busRdata(busRdata));
	sqgr_regs uut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .busValid(busValid),
		.busWrite(busWrite), .busSuper(busSuper), .busAddr(busAddr), .busWdata(busWdata),
		.busByteEn(busByteEn), .addressAck(addressAck), .busErr(busErr), .busRdata(busRdata),
		.ackCycle(ackCycle), .ackLevel(ackLevel), .freezeIn(freezeIn), .testMode(testMode),
		.xferBoundary(evt[0]), .queueDone(evt[1]), .modeFault(evt[2]),
		.moduleClkEn(moduleClkEn), .engineRun(engineRun), .pinHold(pinHold),
		.irqLevel(irqLevel), .arbRequest(arbRequest), .arbId(arbId), .ackVector(ackVector),
		.scanEnable(scanEnable), .scanSelect(scanSelect));

	//////////////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] vecExp(input logic [7:0] v);
		return {v[7:1], 1'b1};
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			nErrors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic acc(input logic wr, input logic sup, input logic [11:0] a,
		input logic [15:0] wd, input logic [1:0] be);
		cpu.xfer(wr, sup, a, wd, be, ack, err, rd);
	endtask

	task automatic pulse(input logic [2:0] e);
		@(posedge core_clk);
		evt <= e;
		@(posedge core_clk);
		evt <= 3'h0;
		@(negedge core_clk);
	endtask

	task automatic printVerdict;
		$display("compares=%0d errors=%0d", compares, nErrors);
		if (nErrors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	//////////////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge core_clk);
		nErrors++;
		printVerdict();
	end

	initial begin
		void'($urandom(32'h4a8b));
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		chk(16'(moduleClkEn), 16'h0001);
		acc(1'b0, 1'b1, sqgr_pkg::IrqVectorOff, 16'h0000, 2'b01);
		chk(16'(rd[7:0]), 16'h000f);
		acc(1'b0, 1'b1, sqgr_pkg::ModuleConfigOff, 16'h0000, 2'b11);
		chk(rd, 16'h0080);
		chk(16'(arbId), 16'h0000);
		pulse(3'b001);
		chk(16'(engineRun), 16'h0000);
		$display("done: reset");

		acc(1'b1, 1'b0, sqgr_pkg::ModuleConfigOff, 16'h0000, 2'b11);
		chk(16'(ack), 16'h0000);
		id = 4'($urandom_range(15, 1));
		acc(1'b1, 1'b1, sqgr_pkg::ModuleConfigOff, {12'h000, id}, 2'b11);
		acc(1'b1, 1'b0, sqgr_pkg::ModuleConfigOff, 16'h8080, 2'b11);
		chk(16'({ack, err}), 16'h0003);
		acc(1'b0, 1'b1, sqgr_pkg::ModuleConfigOff, 16'h0000, 2'b11);
		chk(rd, {12'h000, id});
		chk(16'(arbId), 16'(id));
		acc(1'b0, 1'b0, sqgr_pkg::IrqLevelOff, 16'h0000, 2'b11);
		chk(16'({ack, err}), 16'h0003);
		$display("done: access gating");

		acc(1'b1, 1'b1, sqgr_pkg::ModuleTestOff, 16'h000a, 2'b11);
		chk(16'(err), 16'h0001);
		@(posedge core_clk);
		testMode <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			acc(1'b1, 1'b1, sqgr_pkg::ModuleTestOff, {12'h000, i[1], 1'b0, i[0], 1'b0}, 2'b11);
			chk(16'({scanSelect, scanEnable}), 16'(i));
		end
		@(posedge core_clk);
		testMode <= 1'b0;
		$display("done: test register");

		acc(1'b1, 1'b1, sqgr_pkg::PortDataOff, 16'h00ff, 2'b01);
		acc(1'b1, 1'b1, sqgr_pkg::PortDirOff, 16'h00ff, 2'b01);
		for (int i = 0; i < 4; i++) begin
			lvl = 3'($urandom);
			vec = 8'($urandom_range(255, 64)) & 8'hfe;
			acc(1'b1, 1'b1, sqgr_pkg::IrqLevelOff, {2'b00, lvl, 11'h000}, 2'b10);
			chk(16'(irqLevel), 16'(lvl));
			acc(1'b1, 1'b1, sqgr_pkg::IrqVectorOff, {8'h00, vec}, 2'b01);
			acc(1'b0, 1'b1, sqgr_pkg::IrqVectorOff, 16'h0000, 2'b01);
			chk(16'(rd[7:0]), 16'(vecExp(vec)));
		end
		$display("done: level and vector");

		acc(1'b1, 1'b1, sqgr_pkg::IrqLevelOff, 16'h3800, 2'b10);
		acc(1'b1, 1'b1, sqgr_pkg::QueueStatusOff, 16'h0c00, 2'b11);
		@(negedge core_clk);
		chk(16'(engineRun), 16'h0001);
		pulse(3'b010);
		for (int i = 0; i < 4 && arbRequest !== 1'b1; i++) @(negedge core_clk);
		chk(16'(arbRequest), 16'h0001);
		@(posedge core_clk);
		ackLevel <= 3'h7;
		ackCycle <= 1'b1;
		for (int i = 0; i < 4 && ackVector === 8'h00; i++) @(negedge core_clk);
		chk(16'(ackVector), 16'(vecExp(vec)));
		@(posedge core_clk);
		ackCycle <= 1'b0;
		acc(1'b1, 1'b1, sqgr_pkg::IrqLevelOff, 16'h0000, 2'b10);
		acc(1'b1, 1'b1, sqgr_pkg::QueueStatusOff, 16'h0c00, 2'b11);
		pulse(3'b010);
		repeat (4) @(negedge core_clk);
		chk(16'(arbRequest), 16'h0000);
		acc(1'b1, 1'b1, sqgr_pkg::IrqLevelOff, 16'h3800, 2'b10);
		acc(1'b1, 1'b1, sqgr_pkg::QueueStatusOff, 16'h0a00, 2'b11);
		pulse(3'b100);
		for (int i = 0; i < 4 && arbRequest !== 1'b1; i++) @(negedge core_clk);
		chk(16'(arbRequest), 16'h0001);
		acc(1'b1, 1'b1, sqgr_pkg::QueueStatusOff, 16'h0800, 2'b11);
		$display("done: interrupts");

		for (int f = 1; f >= 0; f--) begin
			acc(1'b1, 1'b1, sqgr_pkg::ModuleConfigOff, {1'b0, f[0], 10'h000, id}, 2'b11);
			@(posedge core_clk);
			freezeIn <= 1'b1;
			repeat (4) @(negedge core_clk);
			pulse(3'b001);
			for (int i = 0; i < 6 && pinHold !== f[0]; i++) @(negedge core_clk);
			chk(16'({pinHold, engineRun}), f ? 16'h0002 : 16'h0001);
			@(posedge core_clk);
			freezeIn <= 1'b0;
			for (int i = 0; i < 8 && engineRun !== 1'b1; i++) @(negedge core_clk);
			chk(16'(engineRun), 16'h0001);
		end
		$display("done: freeze");

		// Frozen clock enable: access not taken, vector kept
		@(posedge core_clk);
		clkEn <= 1'b0;
		acc(1'b1, 1'b1, sqgr_pkg::IrqVectorOff, 16'h0042, 2'b01);
		chk(16'(ack), 16'h0000);
		@(posedge core_clk);
		clkEn <= 1'b1;
		acc(1'b0, 1'b1, sqgr_pkg::IrqVectorOff, 16'h0000, 2'b01);
		chk(16'(rd[7:0]), 16'(vecExp(vec)));
		$display("done: clock enable");

		acc(1'b1, 1'b1, sqgr_pkg::QueueStatusOff, 16'h0900, 2'b11);
		pulse(3'b001);
		rd = 16'h0000;
		for (int i = 0; i < 4 && rd[5] !== 1'b1; i++) begin
			acc(1'b0, 1'b1, sqgr_pkg::QueueStatusOff, 16'h0000, 2'b11);
		end
		acc(1'b1, 1'b1, sqgr_pkg::ModuleConfigOff, {12'h800, id}, 2'b11);
		chk(16'(moduleClkEn), 16'h0000);
		acc(1'b0, 1'b1, sqgr_pkg::IrqVectorOff, 16'h0000, 2'b01);
		chk(rd, 16'h0000);
		acc(1'b0, 1'b1, sqgr_pkg::ModuleConfigOff, 16'h0000, 2'b11);
		chk(rd, {12'h800, id});
		acc(1'b1, 1'b1, sqgr_pkg::IrqVectorOff, 16'h0042, 2'b01);
		acc(1'b1, 1'b1, sqgr_pkg::ModuleConfigOff, {12'h000, id}, 2'b11);
		@(negedge core_clk);
		chk(16'(moduleClkEn), 16'h0001);
		acc(1'b0, 1'b1, sqgr_pkg::IrqVectorOff, 16'h0000, 2'b01);
		chk(16'(rd[7:0]), 16'h0043);
		acc(1'b1, 1'b1, sqgr_pkg::ModuleConfigOff, 16'h8000, 2'b11);
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		chk(16'(moduleClkEn), 16'h0001);
		acc(1'b0, 1'b1, sqgr_pkg::ModuleConfigOff, 16'h0000, 2'b11);
		chk(rd, 16'h0080);
		$display("done: stop");
		printVerdict();
	end
endmodule // sqgr_regs_tb_top
